// *** hw/bst_defs.vh ***
// Constants of the boundary-scan test port
`ifndef BST_DEFS_VH
`define BST_DEFS_VH
`define BST_IR_W        4
`define BST_OP_EXTEST   4'h0
`define BST_OP_IDCODE   4'h1
`define BST_OP_HIGHZ    4'h4
`define BST_OP_SAMPLE   4'h5
`define BST_OP_INTEST   4'h6
`define BST_OP_CLAMP    4'h7
`define BST_OP_BYPASS   4'hF
`define BST_IR_CAPTURE  4'h1
`define BST_ID_W        32
`define BST_ID_LSB      1'b1
`define BST_ID_VER      4'h1
`define BST_ID_PART     16'h1234
`define BST_ID_MAKER    11'h155
`define BST_S_RESET     4'h0
`define BST_S_IDLE      4'h1
`define BST_S_SELDR     4'h2
`define BST_S_CAPDR     4'h3
`define BST_S_SHDR      4'h4
`define BST_S_EX1DR     4'h5
`define BST_S_PAUSEDR   4'h6
`define BST_S_EX2DR     4'h7
`define BST_S_UPDDR     4'h8
`define BST_S_SELIR     4'h9
`define BST_S_CAPIR     4'hA
`define BST_S_SHIR      4'hB
`define BST_S_EX1IR     4'hC
`define BST_S_PAUSEIR   4'hD
`define BST_S_EX2IR     4'hE
`define BST_S_UPDIR     4'hF
`endif

// *** hw/bst_sync.v ***
// Two-flop synchroniser for one level
module bst_sync (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg meta_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// *** hw/bst_tap.v ***
// Boundary-scan test access port with boundary chain
`include "bst_defs.vh"

// Operation
// (RL1) Instruction register is four bits
// (RL2) Codes 0000 EXTEST, 0001 IDCODE, 1111 BYPASS
// (RL3) Standard TAP state machine, TMS on rise
// (RL4) TDI captured on rising TCK
// (RL5) TDO enabled only in shift states, falling
// (RL6) Test reset forces reset state asynchronously; code synchronises it to clk, so it acts a few clocks late
// (RL7) EXTEST drives outputs, captures pin inputs
// (RL8) INTEST drives core inputs, captures core outputs
// (RL9) SAMPLE/PRELOAD snapshots pins, normal mode
// (RL10) Update stage reaches pins only in test
// (RL11) IDCODE 32 bits, LSB first, LSB one
// (RL12) CLAMP holds pins, bypass path, no update
// (RL13) HIGHZ floats outputs, bypass selected
// (RL14) Bypass delays TDI one TCK cycle
// (RL15) Cells: input one, output two, bidir three
// (RL16) Test logic sequenced from TCK alone
// (RL17) Unknown codes behave as BYPASS
module bst_tap #(
  parameter N_IN  = 4,
  parameter N_OUT = 4,
  parameter N_BI  = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             tck,
  input  wire             tms,
  input  wire             tdi,
  input  wire             trst_n,
  output reg              tdo_o,
  output reg              tdo_oe,
  input  wire [N_IN-1:0]  pin_in,
  output reg  [N_IN-1:0]  core_in,
  input  wire [N_OUT-1:0] core_out,
  input  wire [N_OUT-1:0] core_out_en,
  output reg  [N_OUT-1:0] pin_out,
  output reg  [N_OUT-1:0] pin_out_en,
  input  wire [N_BI-1:0]  bi_pin_in,
  output reg  [N_BI-1:0]  bi_core_in,
  input  wire [N_BI-1:0]  bi_core_out,
  input  wire [N_BI-1:0]  bi_core_en,
  output reg  [N_BI-1:0]  bi_pin_out,
  output reg  [N_BI-1:0]  bi_pin_en
);
  // ----------------------------------------
  // Chain layout
  // ----------------------------------------
  // (RL15) one, two and three cells per pin
  localparam CH_W = N_IN + 2 * N_OUT + 3 * N_BI;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire trst_s;
  bst_sync u_tck (.clk(clk), .rst(rst), .din(tck), .dout(tck_s));
  bst_sync u_tms (.clk(clk), .rst(rst), .din(tms), .dout(tms_s));
  bst_sync u_tdi (.clk(clk), .rst(rst), .din(tdi), .dout(tdi_s));
  bst_sync u_trst (.clk(clk), .rst(rst), .din(~trst_n), .dout(trst_s));

  // (RL16) phases found from TCK edges only
  reg  tck_q;
  wire tck_rise = tck_s & ~tck_q;
  wire tck_fall = ~tck_s & tck_q;

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  reg [3:0]          st_q;
  reg [3:0]          st_d;
  reg [`BST_IR_W-1:0] ir_sh_q;
  reg [`BST_IR_W-1:0] ir_q;
  reg                byp_q;
  reg [`BST_ID_W-1:0] id_q;
  reg [CH_W-1:0]     ch_q;
  reg [CH_W-1:0]     upd_q;
  reg                highz_q;

  wire [`BST_ID_W-1:0] id_val = {`BST_ID_VER, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_LSB};

  // (RL2) decode; (RL17) all else is bypass
  wire op_ext   = (ir_q == `BST_OP_EXTEST);
  wire op_id    = (ir_q == `BST_OP_IDCODE);
  wire op_samp  = (ir_q == `BST_OP_SAMPLE);
  wire op_int   = (ir_q == `BST_OP_INTEST);
  wire op_clamp = (ir_q == `BST_OP_CLAMP);
  wire sel_bs   = op_ext | op_samp | op_int;
  // (RL10) test mode only for these codes
  wire pin_test = op_ext | op_clamp;

  // ----------------------------------------
  // TAP state machine
  // ----------------------------------------
  // (RL3) next state chosen by TMS
  always @* begin
    st_d = st_q;
    case (st_q)
      `BST_S_RESET:   st_d = tms_s ? `BST_S_RESET : `BST_S_IDLE;
      `BST_S_IDLE:    st_d = tms_s ? `BST_S_SELDR : `BST_S_IDLE;
      `BST_S_SELDR:   st_d = tms_s ? `BST_S_SELIR : `BST_S_CAPDR;
      `BST_S_CAPDR:   st_d = tms_s ? `BST_S_EX1DR : `BST_S_SHDR;
      `BST_S_SHDR:    st_d = tms_s ? `BST_S_EX1DR : `BST_S_SHDR;
      `BST_S_EX1DR:   st_d = tms_s ? `BST_S_UPDDR : `BST_S_PAUSEDR;
      `BST_S_PAUSEDR: st_d = tms_s ? `BST_S_EX2DR : `BST_S_PAUSEDR;
      `BST_S_EX2DR:   st_d = tms_s ? `BST_S_UPDDR : `BST_S_SHDR;
      `BST_S_UPDDR:   st_d = tms_s ? `BST_S_SELDR : `BST_S_IDLE;
      `BST_S_SELIR:   st_d = tms_s ? `BST_S_RESET : `BST_S_CAPIR;
      `BST_S_CAPIR:   st_d = tms_s ? `BST_S_EX1IR : `BST_S_SHIR;
      `BST_S_SHIR:    st_d = tms_s ? `BST_S_EX1IR : `BST_S_SHIR;
      `BST_S_EX1IR:   st_d = tms_s ? `BST_S_UPDIR : `BST_S_PAUSEIR;
      `BST_S_PAUSEIR: st_d = tms_s ? `BST_S_EX2IR : `BST_S_PAUSEIR;
      `BST_S_EX2IR:   st_d = tms_s ? `BST_S_UPDIR : `BST_S_SHIR;
      default:        st_d = tms_s ? `BST_S_SELDR : `BST_S_IDLE;
    endcase
  end

  // Capture values: pins for EXTEST/SAMPLE, core side for INTEST
  reg [CH_W-1:0] cap_v;
  always @* begin
    cap_v = {CH_W{1'b0}};
    if (op_int) begin
      // (RL8) core output levels captured
      cap_v = {bi_core_en, bi_core_out, bi_core_out, core_out_en, core_out, pin_in};
    end else begin
      // (RL7) (RL9) pin levels captured
      cap_v = {bi_core_en, bi_core_out, bi_pin_in, core_out_en, core_out, pin_in};
    end
  end

  // Serial path ahead of TDO
  reg tdo_d;
  always @* begin
    tdo_d = byp_q;
    if (st_q == `BST_S_SHIR) begin
      tdo_d = ir_sh_q[0];
    end else if (sel_bs) begin
      tdo_d = ch_q[0];
    end else if (op_id) begin
      // (RL11) LSB first
      tdo_d = id_q[0];
    end
  end

  // ----------------------------------------
  // TCK-sequenced test logic
  // ----------------------------------------
  // Level of TCK one clock back, for edge finding
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck_s;
    end
  end

  // Test reset is synchronised, so it acts a few clocks late as a trade-off
  // (RL6) test reset wins without TCK edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= `BST_S_RESET;
    end else if (trst_s) begin
      st_q <= `BST_S_RESET;
    end else if (tck_rise) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Instruction path
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_sh_q <= `BST_IR_CAPTURE;
    end else if (tck_rise && !trst_s) begin
      if (st_q == `BST_S_CAPIR) begin
        ir_sh_q <= `BST_IR_CAPTURE;
      end else if (st_q == `BST_S_SHIR) begin
        // (RL1) (RL4) four-bit shift from TDI
        ir_sh_q <= {tdi_s, ir_sh_q[`BST_IR_W-1:1]};
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_q    <= `BST_OP_IDCODE;
      highz_q <= 1'b0;
    end else if (trst_s) begin
      ir_q    <= `BST_OP_IDCODE;
      highz_q <= 1'b0;
    end else if (tck_rise && st_q == `BST_S_RESET) begin
      ir_q    <= `BST_OP_IDCODE;
      highz_q <= 1'b0;
    end else if (tck_fall && st_q == `BST_S_UPDIR) begin
      ir_q <= ir_sh_q;
      // (RL13) high impedance from Update-IR
      highz_q <= (ir_sh_q == `BST_OP_HIGHZ);
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      byp_q <= 1'b0;
      id_q  <= {`BST_ID_W{1'b0}};
    end else if (tck_rise && !trst_s) begin
      if (st_q == `BST_S_CAPDR) begin
        byp_q <= 1'b0;
        id_q  <= id_val;
      end else if (st_q == `BST_S_SHDR) begin
        // (RL14) one-stage bypass register
        byp_q <= tdi_s;
        id_q  <= {tdi_s, id_q[`BST_ID_W-1:1]};
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ch_q <= {CH_W{1'b0}};
    end else if (tck_rise && !trst_s && sel_bs) begin
      if (st_q == `BST_S_CAPDR) begin
        ch_q <= cap_v;
      end else if (st_q == `BST_S_SHDR) begin
        ch_q <= {tdi_s, ch_q[CH_W-1:1]};
      end
    end
  end

  // (RL10) (RL12) update stage; CLAMP leaves it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      upd_q <= {CH_W{1'b0}};
    end else if (tck_fall && !trst_s && st_q == `BST_S_UPDDR && sel_bs) begin
      upd_q <= ch_q;
    end
  end

  // ----------------------------------------
  // Test data output
  // ----------------------------------------
  // (RL5) TDO moves on falling TCK
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (trst_s) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (st_q == `BST_S_SHIR) | (st_q == `BST_S_SHDR);
      tdo_o  <= tdo_d;
    end
  end

  // ----------------------------------------
  // Boundary cell muxes, registered outputs
  // ----------------------------------------
  wire [N_IN-1:0]  u_in   = upd_q[N_IN-1:0];
  wire [N_OUT-1:0] u_out  = upd_q[N_IN+N_OUT-1:N_IN];
  wire [N_OUT-1:0] u_oen  = upd_q[N_IN+2*N_OUT-1:N_IN+N_OUT];
  wire [N_BI-1:0]  u_bin  = upd_q[N_IN+2*N_OUT+N_BI-1:N_IN+2*N_OUT];
  wire [N_BI-1:0]  u_bout = upd_q[N_IN+2*N_OUT+2*N_BI-1:N_IN+2*N_OUT+N_BI];
  wire [N_BI-1:0]  u_ben  = upd_q[CH_W-1:N_IN+2*N_OUT+2*N_BI];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      core_in    <= {N_IN{1'b0}};
      pin_out    <= {N_OUT{1'b0}};
      pin_out_en <= {N_OUT{1'b0}};
      bi_core_in <= {N_BI{1'b0}};
      bi_pin_out <= {N_BI{1'b0}};
      bi_pin_en  <= {N_BI{1'b0}};
    end else begin
      // (RL8) INTEST feeds core from update stage
      core_in    <= op_int ? u_in : pin_in;
      bi_core_in <= op_int ? u_bin : bi_pin_in;
      // (RL7) (RL12) test mode drives pins
      pin_out    <= pin_test ? u_out : core_out;
      bi_pin_out <= pin_test ? u_bout : bi_core_out;
      if (highz_q) begin
        // (RL13) all outputs floated
        pin_out_en <= {N_OUT{1'b0}};
        bi_pin_en  <= {N_BI{1'b0}};
      end else begin
        pin_out_en <= pin_test ? u_oen : core_out_en;
        bi_pin_en  <= pin_test ? u_ben : bi_core_en;
      end
    end
  end
endmodule

// *** verif/bst_tap_properties.sv ***
// Checker for the boundary-scan test port
module bst_props #(
  parameter N_IN  = 4,
  parameter N_OUT = 4,
  parameter N_BI  = 2
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             tck,
  input wire logic             trst_n,
  input wire logic             tdo_o,
  input wire logic             tdo_oe,
  input wire logic [N_IN-1:0]  pin_in,
  input wire logic [N_IN-1:0]  core_in,
  input wire logic [N_OUT-1:0] core_out,
  input wire logic [N_OUT-1:0] core_out_en,
  input wire logic [N_OUT-1:0] pin_out,
  input wire logic [N_OUT-1:0] pin_out_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ------------------------------
  // Timing and reset relations
  // ------------------------------
  // Normal-mode pin changes follow the core by one clock, so they are excluded
  a_tdo_fall: assert property ($changed(tdo_o) |-> !tck)
    else $error("tdo changed while tck high");
  a_oe_fall: assert property ($changed(tdo_oe) && trst_n && $past(trst_n, 4) |-> !tck)
    else $error("tdo enable changed while tck high");
  a_pin_upd_fall: assert property ($changed(pin_out) && trst_n
    && $past(core_out, 2) == $past(core_out) |-> !tck)
    else $error("pin output updated while tck high");
  a_en_upd_fall: assert property ($changed(pin_out_en) && trst_n
    && $past(core_out_en, 2) == $past(core_out_en) |-> !tck)
    else $error("pin enable updated while tck high");
  a_trst_oe: assert property (!trst_n [*5] |-> !tdo_oe)
    else $error("tdo enabled during test reset");
  a_trst_pins: assert property ((!trst_n && $stable(core_out)) [*6] |-> pin_out == core_out)
    else $error("pins not normal during test reset");
  a_trst_en: assert property ((!trst_n && $stable(core_out_en)) [*6]
    |-> pin_out_en == core_out_en)
    else $error("enables not normal during test reset");
  a_trst_core: assert property ((!trst_n && $stable(pin_in)) [*6] |-> core_in == pin_in)
    else $error("core inputs not normal during test reset");
  c_shift: cover property ($rose(tdo_oe));
  c_float: cover property ($fell(pin_out_en));
  c_trst: cover property ($fell(trst_n));
endmodule
bind bst_tap bst_props #(.N_IN(N_IN), .N_OUT(N_OUT), .N_BI(N_BI)) chk_u (.*);

// *** verif/bst_tester.sv ***
// Model of the external test controller on the test pins
module bst_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_o,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // pins set half a period before rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #32;
    // Released line shows the inverse, not a stale copy
    q = tdo_oe ? tdo_o : ~tdo_o;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the boundary-scan test port
`include "bst_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam L = 18;
  localparam logic [17:0] P = 18'h2D5E3;
  logic       clk, rst, trst_n, tck, tms, tdi, tdo_o, tdo_oe, b;
  logic [3:0] pin_in, core_in, core_out, core_out_en, pin_out, pin_out_en;
  logic [1:0] bi_pin_in, bi_core_in, bi_core_out, bi_core_en, bi_pin_out, bi_pin_en;
  int         err_total, num_checks;
  bst_tap    dut_u (.*);
  bst_tester tst_u (.*);
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // From idle through capture, shift n bits LSB first, update, back to idle
  task automatic scan(input bit ir, input logic [31:0] d, input int n, output logic [31:0] q);
    q = '0;
    tst_u.step(1'b1, 1'b0, b);
    if (ir) tst_u.step(1'b1, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tst_u.step(i == n - 1, d[i], b);
      q[i] = b;
    end
    tst_u.step(1'b1, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_idcode();
    logic [31:0] q;
    tst_u.step(1'b0, 1'b0, b);
    chk("tdo_oe_idle", tdo_oe, 1'b0);
    scan(0, '0, 32, q);
    chk("idcode", q, {`BST_ID_VER, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_LSB});
  endtask
  task automatic t_bypass();
    logic [3:0]  c [4] = '{`BST_OP_BYPASS, 4'hA, `BST_OP_CLAMP, `BST_OP_HIGHZ};
    logic [31:0] q;
    foreach (c[k]) begin
      scan(1, c[k], 4, q);
      chk("ir_capture", q, `BST_IR_CAPTURE);
      scan(0, 32'h5B, 8, q);
      chk("bypass", q, 32'hB6);
      if (k == 1) chk("unknown_pins", pin_out, core_out);
    end
  endtask
  task automatic t_bscan();
    logic [31:0] q;
    scan(1, `BST_OP_SAMPLE, 4, q);
    scan(0, P, L, q);
    chk("sample", q, {2'h3, 2'h2, 2'h1, 4'hC, 4'h6, 4'hA});
    chk("normal_pins", pin_out, core_out);
    scan(1, `BST_OP_EXTEST, 4, q);
    chk("extest_out", {bi_pin_en, bi_pin_out, pin_out_en, pin_out}, {P[17:14], P[11:4]});
    scan(0, P, L, q);
    chk("extest_cap", q[3:0], 4'hA);
    scan(1, `BST_OP_HIGHZ, 4, q);
    chk("highz_en", {bi_pin_en, pin_out_en}, 6'h00);
    scan(1, `BST_OP_CLAMP, 4, q);
    scan(0, '0, L, q);
    chk("clamp_out", pin_out, P[7:4]);
    scan(1, `BST_OP_INTEST, 4, q);
    chk("intest_in", {bi_core_in, core_in}, {P[13:12], P[3:0]});
  endtask
  task automatic t_trst();
    tst_u.step(1'b1, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
    #40;
    chk("oe_shift", tdo_oe, 1'b1);
    @(posedge clk);
    #1 trst_n = 1'b0;
    core_out = 4'h9;
    repeat (10) @(posedge clk);
    #1;
    chk("oe_trst", tdo_oe, 1'b0);
    chk("trst_pins", pin_out, 4'h9);
    trst_n = 1'b1;
    t_idcode();
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is about 20 us of test clock traffic
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    trst_n = 1'b1;
    pin_in = 4'hA;
    core_out = 4'h6;
    core_out_en = 4'hC;
    bi_pin_in = 2'h1;
    bi_core_out = 2'h2;
    bi_core_en = 2'h3;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    t_idcode();
    t_bypass();
    t_bscan();
    t_trst();
    stop_test();
  end
endmodule
